// ==== design/tef_pkg.sv ====
package tef_pkg;

  localparam int unsigned NUM_CHAN = 4;

  // Register byte addresses
  localparam logic [7:0] OFF_IRQ_DMA_EN = 8'h0C;
  localparam logic [7:0] OFF_STATUS     = 8'h10;
  localparam logic [7:0] OFF_EVENT_GEN  = 8'h14;
  localparam logic [7:0] OFF_CHAN_MODE  = 8'h18;
  localparam logic [7:0] OFF_CONTROL    = 8'h44;
  localparam logic [3:0][7:0] OFF_COMPARE = {8'h40, 8'h3C, 8'h38, 8'h34};

  // Writable bits of each register; all but event generate also read back
  localparam logic [15:0] MASK_IRQ_DMA_EN = 16'h5F5F;
  localparam logic [15:0] MASK_STATUS     = 16'h1E5F;
  localparam logic [15:0] MASK_EVENT_GEN  = 16'h005F;
  localparam logic [15:0] MASK_CHAN_MODE  = 16'hFFFF;
  localparam logic [15:0] MASK_CONTROL    = 16'h0F1F;
  localparam logic [15:0] MASK_MODE_LOCK  = 16'h0078;
  localparam logic [15:0] RESET_REG       = 16'h0000;

  // Field positions
  localparam int unsigned BIT_UPDATE     = 0;
  localparam int unsigned BIT_CHAN_BASE  = 1;
  localparam int unsigned BIT_TRIGGER    = 6;
  localparam int unsigned BIT_DMA_BASE   = 8;
  localparam int unsigned BIT_REPEAT     = 9;
  localparam int unsigned BIT_FAST       = 2;
  localparam int unsigned BIT_PRELOAD    = 3;
  localparam int unsigned BIT_MODE_LO    = 4;
  localparam int unsigned BIT_EXT_CLEAR  = 7;
  localparam int unsigned BIT_DIR2_LO    = 8;
  localparam int unsigned CTL_UPDATE_DIS = 0;
  localparam int unsigned CTL_UPDATE_SRC = 1;
  localparam int unsigned CTL_COUNT_DOWN = 2;
  localparam int unsigned CTL_CENTER     = 3;
  localparam int unsigned CTL_PROTECT3   = 4;
  localparam int unsigned CTL_ENABLE_LO  = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DIR_OUTPUT = 2'b00,
    DIR_IN_A   = 2'b01,
    DIR_IN_B   = 2'b10,
    DIR_IN_TRC = 2'b11
  } tef_dir_t;

  typedef enum logic [2:0] {
    OM_FROZEN     = 3'b000,
    OM_MATCH_HIGH = 3'b001,
    OM_MATCH_LOW  = 3'b010,
    OM_TOGGLE     = 3'b011,
    OM_FORCE_LOW  = 3'b100,
    OM_FORCE_HIGH = 3'b101,
    OM_PWM1       = 3'b110,
    OM_PWM2       = 3'b111
  } tef_out_mode_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } tef_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tef_axi_rsp_t;

  typedef struct packed {
    logic [15:0] counterValue;
    logic [15:0] reloadValue;
    logic        repeatOverflow;
    logic        counterTriggerReinit;
    logic        triggerEvent;
    logic        captureTimerInputOne;
    logic        captureTimerInputTwo;
    logic        captureTriggerSelect;
    logic        captureThree;
    logic        captureFour;
    logic [1:0]  chanThreeFourInput;
  } tef_timer_in_t;

  typedef struct packed {
    logic        irq;
    logic [5:0]  dmaRequest;
    logic        updateEvent;
    logic        counterLoad;
    logic [15:0] counterLoadValue;
    logic        prescalerClear;
    logic        chan1OutputReference;
  } tef_timer_out_t;

  typedef struct packed {
    logic                      awHeld;
    logic [7:0]                awAddr;
    logic                      wHeld;
    logic [15:0]               wData;
    logic [1:0]                wStrb;
    logic                      awReady;
    logic                      wReady;
    logic                      bValid;
    logic [1:0]                bResp;
    logic                      arReady;
    logic                      rValid;
    logic [15:0]               rData;
    logic [1:0]                rResp;
    logic [15:0]               irqDmaEnable;
    logic [15:0]               status;
    logic [15:0]               chanMode;
    logic [15:0]               control;
    logic [NUM_CHAN-1:0][15:0] comparePreload;
    logic [NUM_CHAN-1:0][15:0] compareActive;
    logic [NUM_CHAN-1:0]       prevMatch;
    logic                      etrMeta;
    logic                      etrSync;
    tef_timer_out_t            out;
  } tef_state_t;

endpackage : tef_pkg

// ==== design/tef_timer_events.sv ====
`timescale 1ns/100ps
// Behaviour
// - Update, channel and trigger interrupts assert only with their enable bit set.
// - DMA requests for update, channels, trigger issue only when enabled.
// - Update flag sets on update event (only on overflow with source select set), stays until software writes 0.
// - Update event from overflow, software request, or trigger reinit with source select clear; not when disabled.
// - Output channel flag sets when counter equals compare value.
// - Input channel flag sets on capture; cleared by writing 0 or reading capture.
// - Repeat-capture flag sets on capture while channel flag already set.
// - Trigger flag sets on each trigger event, cleared by writing 0.
// - Software update reinitialises counter, clears prescaler count, bit self-clears.
// - Software update loads reload value counting down outside center mode, else zero.
// - Channel generate bit sets flag, captures in input mode, self-clears.
// - Trigger generate bit produces trigger event; writing 0 does nothing.
// - Channel-one direction: output, input one, input two, or trigger select.
// - Fast enable shortens trigger-to-output response in PWM modes.
// - Compare writes act at once, or for channel one at next update with preload set.
// - Preload and mode fields locked at protection level 3 in output.
// - Output mode: frozen, high, low or toggle on match.
// - PWM modes follow the comparison, including entry from frozen.
// - Clear enable forces reference low while external trigger is high.
// - Channel-two direction swaps the two timer inputs.
// - Channels two to four flags behave like channel one.
// - Update disable suppresses all update events and shadow refreshes.
module tef_timer_events
  import tef_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // Register bus
  input  wire tef_pkg::tef_axi_req_t   axiReq,
  output tef_pkg::tef_axi_rsp_t        axiRsp,
  // Timer core
  input  wire tef_pkg::tef_timer_in_t  timerIn,
  output tef_pkg::tef_timer_out_t      timerOut,
  // Pin
  input  wire logic                    filteredExternalTrigger
);
  import tef_pkg::*;

  tef_state_t            st;
  tef_state_t            next_st;
  logic                  awTake;
  logic                  wTake;
  logic                  arTake;
  logic                  doWrite;
  logic [15:0]           byteMask;
  logic                  hitWrite;
  logic [15:0]           eventGen;
  logic [15:0]           statusClear;
  logic [15:0]           statusSet;
  logic [15:0]           modeMask;
  logic                  modeLock;
  logic                  updEvt;
  logic                  updFlagSet;
  logic                  swUpdate;
  logic                  trigEvt;
  logic [NUM_CHAN-1:0]   isOut;
  logic [NUM_CHAN-1:0]   capSrc;
  logic [NUM_CHAN-1:0]   capEvt;
  logic [NUM_CHAN-1:0]   match;
  logic [NUM_CHAN-1:0]   matchSet;
  logic [NUM_CHAN-1:0]   chanSet;
  logic [NUM_CHAN-1:0]   readClear;
  logic                  readHit;
  logic [15:0]           readValue;
  logic                  refLess;
  tef_out_mode_t         mode1;

  assign axiRsp.awready = st.awReady;
  assign axiRsp.wready  = st.wReady;
  assign axiRsp.bvalid  = st.bValid;
  assign axiRsp.bresp   = st.bResp;
  assign axiRsp.arready = st.arReady;
  assign axiRsp.rvalid  = st.rValid;
  assign axiRsp.rdata   = {16'h0000, st.rData};
  assign axiRsp.rresp   = st.rResp;
  assign timerOut       = st.out;

  always_comb begin
    next_st = st;
    // Pin synchroniser; only the second stage is used below
    next_st.etrMeta = filteredExternalTrigger;
    next_st.etrSync = st.etrMeta;

    // Write channel: address and data may arrive in either order
    awTake = axiReq.awvalid & st.awReady;
    wTake  = axiReq.wvalid & st.wReady;
    if (awTake) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = axiReq.awaddr;
    end
    if (wTake) begin
      next_st.wHeld = 1'b1;
      next_st.wData = axiReq.wdata[15:0];
      next_st.wStrb = axiReq.wstrb[1:0];
    end
    doWrite  = next_st.awHeld & next_st.wHeld & ~st.bValid;
    byteMask = {{8{next_st.wStrb[1]}}, {8{next_st.wStrb[0]}}};
    hitWrite = 1'b0;
    eventGen = 16'h0000;
    statusClear = 16'h0000;
    modeLock = st.control[CTL_PROTECT3] & (st.chanMode[1:0] == DIR_OUTPUT);
    modeMask = byteMask & MASK_CHAN_MODE & ~(modeLock ? MASK_MODE_LOCK : 16'h0000);
    if (doWrite) begin
      unique case (next_st.awAddr)
        OFF_IRQ_DMA_EN: begin
          hitWrite = 1'b1;
          next_st.irqDmaEnable = (st.irqDmaEnable & ~(byteMask & MASK_IRQ_DMA_EN))
                               | (next_st.wData & byteMask & MASK_IRQ_DMA_EN);
        end
        OFF_STATUS: begin
          hitWrite    = 1'b1;
          statusClear = ~next_st.wData & byteMask & MASK_STATUS;
        end
        OFF_EVENT_GEN: begin
          hitWrite = 1'b1;
          eventGen = next_st.wData & byteMask & MASK_EVENT_GEN;
        end
        OFF_CHAN_MODE: begin
          hitWrite = 1'b1;
          next_st.chanMode = (st.chanMode & ~modeMask) | (next_st.wData & modeMask);
        end
        OFF_CONTROL: begin
          hitWrite = 1'b1;
          next_st.control = (st.control & ~(byteMask & MASK_CONTROL))
                          | (next_st.wData & byteMask & MASK_CONTROL);
        end
        default: begin
          hitWrite = 1'b0;
        end
      endcase
    end

    // Channel direction and capture source
    isOut[0]  = st.chanMode[1:0] == DIR_OUTPUT;
    isOut[1]  = st.chanMode[BIT_DIR2_LO +: 2] == DIR_OUTPUT;
    isOut[2]  = ~timerIn.chanThreeFourInput[0];
    isOut[3]  = ~timerIn.chanThreeFourInput[1];
    unique case (tef_dir_t'(st.chanMode[1:0]))
      DIR_IN_A:   capSrc[0] = timerIn.captureTimerInputOne;
      DIR_IN_B:   capSrc[0] = timerIn.captureTimerInputTwo;
      DIR_IN_TRC: capSrc[0] = timerIn.captureTriggerSelect;
      DIR_OUTPUT: capSrc[0] = 1'b0;
    endcase
    unique case (tef_dir_t'(st.chanMode[BIT_DIR2_LO +: 2]))
      DIR_IN_A:   capSrc[1] = timerIn.captureTimerInputTwo;
      DIR_IN_B:   capSrc[1] = timerIn.captureTimerInputOne;
      DIR_IN_TRC: capSrc[1] = timerIn.captureTriggerSelect;
      DIR_OUTPUT: capSrc[1] = 1'b0;
    endcase
    capSrc[2] = timerIn.captureThree;
    capSrc[3] = timerIn.captureFour;

    // Update and trigger events
    swUpdate   = eventGen[BIT_UPDATE];
    updEvt     = ~st.control[CTL_UPDATE_DIS] & (timerIn.repeatOverflow | swUpdate
               | (timerIn.counterTriggerReinit & ~st.control[CTL_UPDATE_SRC]));
    // With the source select set only overflow raises the flag and its requests
    updFlagSet = updEvt & (~st.control[CTL_UPDATE_SRC] | timerIn.repeatOverflow);
    trigEvt    = timerIn.triggerEvent | eventGen[BIT_TRIGGER];

    // Reading a capture register, this cycle's read address
    arTake    = axiReq.arvalid & st.arReady;
    readHit   = 1'b1;
    readValue = 16'h0000;
    readClear = '0;
    statusSet = 16'h0000;
    statusSet[BIT_UPDATE]  = updFlagSet;
    statusSet[BIT_TRIGGER] = trigEvt;

    // Preloaded compare value moves to the active copy on update
    if (updEvt && st.chanMode[BIT_PRELOAD] && isOut[0]) begin
      next_st.compareActive[0] = st.comparePreload[0];
    end
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (doWrite && next_st.awAddr == OFF_COMPARE[i]) begin
        hitWrite = 1'b1;
        next_st.comparePreload[i] = (st.comparePreload[i] & ~byteMask)
                                  | (next_st.wData & byteMask);
        if (!(i == 0 && st.chanMode[BIT_PRELOAD])) begin
          next_st.compareActive[i] = next_st.comparePreload[i];
        end
      end
      match[i]    = timerIn.counterValue == st.compareActive[i];
      matchSet[i] = isOut[i] & match[i] & ~st.prevMatch[i];
      next_st.prevMatch[i] = match[i];
      capEvt[i]   = ~isOut[i] & ((capSrc[i] & st.control[CTL_ENABLE_LO + i])
                  | eventGen[BIT_CHAN_BASE + i]);
      chanSet[i]  = matchSet[i] | capEvt[i] | eventGen[BIT_CHAN_BASE + i];
      if (capEvt[i]) begin
        next_st.compareActive[i]  = timerIn.counterValue;
        next_st.comparePreload[i] = timerIn.counterValue;
      end
      statusSet[BIT_CHAN_BASE + i] = chanSet[i];
      statusSet[BIT_REPEAT + i]    = capEvt[i] & st.status[BIT_CHAN_BASE + i];
      readClear[i] = arTake && axiReq.araddr == OFF_COMPARE[i];
      statusClear[BIT_CHAN_BASE + i] = statusClear[BIT_CHAN_BASE + i] | readClear[i];
    end
    // A flag event in the clearing cycle is kept
    next_st.status = ((st.status & ~statusClear) | statusSet) & MASK_STATUS;

    // Register read
    unique case (axiReq.araddr)
      OFF_IRQ_DMA_EN: readValue = st.irqDmaEnable;
      OFF_STATUS:     readValue = st.status;
      OFF_EVENT_GEN:  readValue = RESET_REG;
      OFF_CHAN_MODE:  readValue = st.chanMode;
      OFF_CONTROL:    readValue = st.control;
      default:        readHit = 1'b0;
    endcase
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (axiReq.araddr == OFF_COMPARE[i]) begin
        readHit   = 1'b1;
        readValue = st.compareActive[i];
      end
    end
    if (st.rValid && axiReq.rready) begin
      next_st.rValid = 1'b0;
    end
    if (arTake) begin
      next_st.rValid = 1'b1;
      next_st.rData  = readHit ? readValue : 16'h0000;
      next_st.rResp  = readHit ? RESP_OKAY : RESP_SLVERR;
    end
    next_st.arReady = ~next_st.rValid;
    if (st.bValid && axiReq.bready) begin
      next_st.bValid = 1'b0;
    end
    if (doWrite) begin
      next_st.bValid = 1'b1;
      next_st.bResp  = hitWrite ? RESP_OKAY : RESP_SLVERR;
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
    end
    next_st.awReady = ~next_st.awHeld & ~next_st.bValid;
    next_st.wReady  = ~next_st.wHeld & ~next_st.bValid;

    // Timer-facing pulses
    next_st.out.irq = |(next_st.status[6:0] & st.irqDmaEnable[6:0]);
    next_st.out.dmaRequest = {trigEvt, chanSet, updFlagSet}
                           & {st.irqDmaEnable[14], st.irqDmaEnable[12:8]};
    next_st.out.updateEvent    = updEvt;
    next_st.out.counterLoad    = swUpdate;
    next_st.out.prescalerClear = swUpdate;
    next_st.out.counterLoadValue = (st.control[CTL_COUNT_DOWN] & ~st.control[CTL_CENTER])
                                 ? timerIn.reloadValue : 16'h0000;

    // Channel-one output reference
    mode1   = tef_out_mode_t'(st.chanMode[BIT_MODE_LO +: 3]);
    refLess = timerIn.counterValue < st.compareActive[0];
    unique case (mode1)
      OM_FROZEN:     next_st.out.chan1OutputReference = st.out.chan1OutputReference;
      OM_MATCH_HIGH: if (matchSet[0]) next_st.out.chan1OutputReference = 1'b1;
      OM_MATCH_LOW:  if (matchSet[0]) next_st.out.chan1OutputReference = 1'b0;
      OM_TOGGLE:     if (matchSet[0]) next_st.out.chan1OutputReference =
                       ~st.out.chan1OutputReference;
      OM_FORCE_LOW:  next_st.out.chan1OutputReference = 1'b0;
      OM_FORCE_HIGH: next_st.out.chan1OutputReference = 1'b1;
      // Recomputed every cycle, so leaving frozen takes effect at once
      OM_PWM1:       next_st.out.chan1OutputReference = refLess;
      OM_PWM2:       next_st.out.chan1OutputReference = ~refLess;
    endcase
    // Fast path: in a PWM mode a trigger drives the below-compare level at once, without waiting for the compare
    if (st.chanMode[BIT_FAST] && trigEvt && mode1[2:1] == 2'b11) begin
      next_st.out.chan1OutputReference = (mode1 == OM_PWM1);
    end
    if ((st.chanMode[BIT_EXT_CLEAR] && st.etrSync) || !isOut[0]) begin
      next_st.out.chan1OutputReference = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st           <= '0;
      // Counter and compare both start at zero, which is not a fresh match
      st.prevMatch <= '1;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seqWriteBoth;
    doWrite;
  endsequence
  sequence seqResponse;
    st.bValid && !st.awReady && !st.wReady;
  endsequence

  a_irq_gated: assert property (st.out.irq |-> |(st.status[6:0] & $past(st.irqDmaEnable[6:0])))
    else $error("interrupt without an enabled flag");
  a_dma_gated: assert property (st.out.dmaRequest[0] |-> $past(st.irqDmaEnable[8]))
    else $error("update request without enable");
  a_update_flag: assert property (updFlagSet |=> st.status[BIT_UPDATE])
    else $error("update flag not set");
  a_update_block: assert property (st.control[CTL_UPDATE_DIS] |=> !st.out.updateEvent)
    else $error("update event while disabled");
  a_match_flag: assert property (isOut[0] && match[0] && !st.prevMatch[0] |=> st.status[1])
    else $error("compare match did not set flag");
  a_repeat_cap: assert property (capEvt[1] && st.status[2] |=> st.status[10])
    else $error("repeat capture flag missing");
  a_trig_flag: assert property (trigEvt |=> st.status[BIT_TRIGGER] ##1 1'b1)
    else $error("trigger flag not set");
  a_load_value: assert property (st.out.counterLoad |-> st.out.counterLoadValue ==
    ($past(st.control[CTL_COUNT_DOWN] & ~st.control[CTL_CENTER]) ?
     $past(timerIn.reloadValue) : 16'h0000))
    else $error("wrong counter load value");
  a_preload_hold: assert property (st.chanMode[BIT_PRELOAD] && !updEvt && !capEvt[0]
    |=> $stable(st.compareActive[0]))
    else $error("preloaded compare changed early");
  a_mode_lock: assert property (modeLock |=> (st.chanMode & MASK_MODE_LOCK) ==
    $past(st.chanMode & MASK_MODE_LOCK))
    else $error("locked mode field changed");
  a_ext_clear: assert property (st.chanMode[BIT_EXT_CLEAR] && st.etrSync
    |=> !st.out.chan1OutputReference)
    else $error("reference not cleared");
  a_write_resp: assert property (seqWriteBoth |=> seqResponse)
    else $error("write response missing");
  a_read_upper: assert property (st.rValid && st.rResp == RESP_SLVERR
    |-> axiRsp.rdata == 32'h0000_0000)
    else $error("unmapped read data not zero");

  // Enables, flags and software events
  a_irq_masked: assert property (st.irqDmaEnable[6:0] == 7'h00 |=> !st.out.irq)
    else $error("interrupt with all enables clear");
  a_dma_trig: assert property (st.out.dmaRequest[5] |-> $past(st.irqDmaEnable[14]))
    else $error("trigger request without enable");
  a_sw_update: assert property (swUpdate && !st.control[CTL_UPDATE_DIS]
    |=> st.out.updateEvent && st.out.counterLoad && st.out.prescalerClear)
    else $error("software update pulses missing");
  a_overflow_upd: assert property (timerIn.repeatOverflow
    && !st.control[CTL_UPDATE_DIS] |=> st.out.updateEvent && st.status[BIT_UPDATE])
    else $error("overflow did not update");
  a_trig_gen: assert property (eventGen[BIT_TRIGGER]
    |=> st.out.dmaRequest[5] == $past(st.irqDmaEnable[14]))
    else $error("trigger generate had no effect");
  a_gen_read: assert property (arTake && axiReq.araddr == OFF_EVENT_GEN
    |=> st.rData == 16'h0000)
    else $error("event generate bits read back");
  a_chan_gen: assert property (eventGen[BIT_CHAN_BASE + 1] |=> st.status[2])
    else $error("channel generate did not set flag");
  a_status_clear: assert property (doWrite && next_st.awAddr == OFF_STATUS
    && next_st.wStrb[0] && !next_st.wData[BIT_TRIGGER] && !trigEvt
    |=> !st.status[BIT_TRIGGER])
    else $error("trigger flag not cleared by zero");
  a_reserved_zero: assert property ((st.status & ~MASK_STATUS) == 16'h0000
    && (st.irqDmaEnable & ~MASK_IRQ_DMA_EN) == 16'h0000)
    else $error("reserved bit set");
  // Capture, compare and output reference
  a_cap_map: assert property (st.chanMode[1:0] == DIR_IN_A
    && st.control[CTL_ENABLE_LO] && timerIn.captureTimerInputOne |=> st.status[1])
    else $error("input one capture lost");
  a_cap_swap: assert property (st.chanMode[BIT_DIR2_LO +: 2] == DIR_IN_A
    && st.control[CTL_ENABLE_LO + 1] && timerIn.captureTimerInputTwo |=> st.status[2])
    else $error("channel two capture not on input two");
  a_cap_value: assert property (capEvt[0]
    |=> st.compareActive[0] == $past(timerIn.counterValue))
    else $error("capture value wrong");
  a_read_clear: assert property (readClear[0] && !chanSet[0] |=> !st.status[1])
    else $error("capture read did not clear flag");
  a_dir_input: assert property (!isOut[0] |=> !st.out.chan1OutputReference)
    else $error("reference driven while input");
  a_match_high: assert property (mode1 == OM_MATCH_HIGH && matchSet[0]
    && !(st.chanMode[BIT_EXT_CLEAR] && st.etrSync) |=> st.out.chan1OutputReference)
    else $error("match did not drive high");
  a_frozen: assert property (mode1 == OM_FROZEN && isOut[0]
    && !(st.chanMode[BIT_EXT_CLEAR] && st.etrSync) |=> $stable(st.out.chan1OutputReference))
    else $error("frozen reference moved");
  a_preload_off: assert property (doWrite && next_st.awAddr == OFF_COMPARE[0]
    && !st.chanMode[BIT_PRELOAD] && !capEvt[0] |=> st.compareActive[0] == st.comparePreload[0])
    else $error("compare write not immediate");

endmodule : tef_timer_events

// ==== tb/tef_timer_events_bench.sv ====
`timescale 1ns/100ps
module tef_timer_events_bench;
  import tef_pkg::*;
  logic           clk;
  logic           rstn;
  tef_axi_req_t   axiReq;
  tef_axi_rsp_t   axiRsp;
  tef_timer_in_t  timerIn;
  tef_timer_out_t timerOut;
  logic           extTrig;
  tef_timer_out_t lastOut;
  logic [31:0]    rd;
  logic [1:0]     resp;
  int             errors;
  int             cmpCount;

  tef_timer_events u_dut (
    .clk                     (clk),
    .rstn                    (rstn),
    .axiReq                  (axiReq),
    .axiRsp                  (axiRsp),
    .timerIn                 (timerIn),
    .timerOut                (timerOut),
    .filteredExternalTrigger (extTrig)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Timer output snapshot is taken at the response edge, one cycle after the write lands
  task automatic axi_write(input logic [7:0] a, input logic [15:0] d);
    logic awDone;
    logic wDone;
    int   n;
    awDone = 1'b0;
    wDone = 1'b0;
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= {16'h0000, d};
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (!awDone && axiRsp.awready === 1'b1) begin
        awDone = 1'b1;
        axiReq.awvalid <= 1'b0;
      end
      if (!wDone && axiRsp.wready === 1'b1) begin
        wDone = 1'b1;
        axiReq.wvalid <= 1'b0;
      end
      if (axiRsp.bvalid === 1'b1) break;
    end
    lastOut = timerOut;
    resp = axiRsp.bresp;
    chk({31'h0, n < 50}, 32'h1, "write response");
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    int n;
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid === 1'b1) break;
    end
    rd = axiRsp.rdata;
    resp = axiRsp.rresp;
    chk({31'h0, n < 50}, 32'h1, "read response");
  endtask : axi_read

  task automatic read_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
    axi_read(a);
    chk(rd, {16'h0000, exp}, what);
  endtask : read_chk

  task automatic t_reset;
    read_chk(OFF_IRQ_DMA_EN, 16'h0000, "enable reset");
    read_chk(OFF_STATUS, 16'h0000, "status reset");
    read_chk(OFF_EVENT_GEN, 16'h0000, "event gen reset");
    read_chk(OFF_CHAN_MODE, 16'h0000, "mode reset");
    read_chk(8'h00, 16'h0000, "unmapped data");
    chk(resp, RESP_SLVERR, "unmapped resp");
    axi_write(8'h00, 16'hFFFF);
    chk(resp, RESP_SLVERR, "unmapped write resp");
    $display("Test reset done");
  endtask : t_reset

  task automatic t_update;
    axi_write(OFF_IRQ_DMA_EN, 16'hFFFF);
    read_chk(OFF_IRQ_DMA_EN, 16'h5F5F, "enable mask");
    axi_write(OFF_EVENT_GEN, 16'h0001);
    chk(lastOut.updateEvent, 1'b1, "sw update event");
    chk(lastOut.counterLoad, 1'b1, "counter load");
    chk(lastOut.prescalerClear, 1'b1, "prescaler clear");
    chk(lastOut.counterLoadValue, 16'h0000, "load value up");
    chk(lastOut.dmaRequest, 6'h01, "update dma");
    read_chk(OFF_STATUS, 16'h0001, "update flag");
    chk(timerOut.irq, 1'b1, "update irq");
    read_chk(OFF_EVENT_GEN, 16'h0000, "update self clear");
    timerIn.reloadValue <= 16'h1234;
    axi_write(OFF_CONTROL, 16'h0004);
    axi_write(OFF_EVENT_GEN, 16'h0001);
    chk(lastOut.counterLoadValue, 16'h1234, "load value down");
    axi_write(OFF_STATUS, 16'h0000);
    read_chk(OFF_STATUS, 16'h0000, "flag cleared");
    chk(timerOut.irq, 1'b0, "irq follows flag");
    timerIn.repeatOverflow <= 1'b1;
    @(posedge clk);
    timerIn.repeatOverflow <= 1'b0;
    read_chk(OFF_STATUS, 16'h0001, "overflow update");
    axi_write(OFF_STATUS, 16'h0000);
    axi_write(OFF_CONTROL, 16'h0001);
    axi_write(OFF_EVENT_GEN, 16'h0001);
    chk(lastOut.updateEvent, 1'b0, "update disabled");
    read_chk(OFF_STATUS, 16'h0000, "no flag disabled");
    $display("Test update done");
  endtask : t_update

  task automatic t_trigger;
    axi_write(OFF_EVENT_GEN, 16'h0040);
    chk(lastOut.dmaRequest, 6'h20, "trigger dma");
    read_chk(OFF_STATUS, 16'h0040, "trigger flag");
    read_chk(OFF_EVENT_GEN, 16'h0000, "trigger self clear");
    axi_write(OFF_IRQ_DMA_EN, 16'h0000);
    @(posedge clk);
    chk(timerOut.irq, 1'b0, "irq masked");
    axi_write(OFF_EVENT_GEN, 16'h0040);
    chk(lastOut.dmaRequest, 6'h00, "dma masked");
    axi_write(OFF_EVENT_GEN, 16'h0004);
    read_chk(OFF_STATUS, 16'h0044, "channel generate");
    $display("Test trigger done");
  endtask : t_trigger

  task automatic t_capture;
    axi_write(OFF_STATUS, 16'h0000);
    axi_write(OFF_CHAN_MODE, 16'h0101);
    axi_write(OFF_CONTROL, 16'h0300);
    timerIn.counterValue <= 16'h00AA;
    repeat (2) begin
      timerIn.captureTimerInputOne <= 1'b1;
      @(posedge clk);
      timerIn.captureTimerInputOne <= 1'b0;
      @(posedge clk);
    end
    timerIn.captureTimerInputTwo <= 1'b1;
    @(posedge clk);
    timerIn.captureTimerInputTwo <= 1'b0;
    read_chk(OFF_STATUS, 16'h0206, "capture and repeat");
    read_chk(OFF_COMPARE[0], 16'h00AA, "captured value");
    read_chk(OFF_STATUS, 16'h0204, "read clears flag");
    $display("Test capture done");
  endtask : t_capture

  task automatic t_compare;
    timerIn.counterValue <= 16'h0000;
    axi_write(OFF_CONTROL, 16'h0000);
    axi_write(OFF_STATUS, 16'h0000);
    axi_write(OFF_CHAN_MODE, 16'h0010);
    axi_write(OFF_COMPARE[0], 16'h0005);
    timerIn.counterValue <= 16'h0005;
    repeat (3) @(posedge clk);
    chk(timerOut.chan1OutputReference, 1'b1, "high on match");
    read_chk(OFF_STATUS, 16'h0002, "compare flag");
    axi_write(OFF_CHAN_MODE, 16'h0090);
    extTrig <= 1'b1;
    repeat (4) @(posedge clk);
    chk(timerOut.chan1OutputReference, 1'b0, "external clear");
    extTrig <= 1'b0;
    $display("Test compare done");
  endtask : t_compare

  initial begin
    errors = 0;
    cmpCount = 0;
    rstn = 1'b0;
    axiReq = '0;
    timerIn = '0;
    extTrig = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_update();
    t_trigger();
    t_capture();
    t_compare();
    print_verdict();
  end

  // Whole run needs well under a few thousand cycles
  initial begin
    #(20000 * 5);
    errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : tef_timer_events_bench
